//--- bench/pdh_sleep_drv.sv
/*
 pdh_sleep_drv: system logic on the far side that drives the two sleep pins.
 assumes: requests come from the bench; the pins are actively driven at all times.
*/
`timescale 1ns/1ns
module pdh_sleep_drv (
	input wire logic ref_clk_in,
	input wire logic [1:0] req_in,
	output logic [1:0] pad_out
);
	logic [1:0] pend_reg;

	always_ff @(posedge ref_clk_in) begin
		pend_reg <= req_in;
	end
	// drive low to resume
	// pins change on the falling edge, away from the sampling edge
	always @(negedge ref_clk_in) begin
		pad_out <= pend_reg;
	end
endmodule

//--- bench/tb_pdh_top.sv
/*
 tb_pdh_top: self-checking scenarios for the power-down hold block.
 assumes: pdh_top with default sizes; sleep pads 1:0 come from the partner model.
*/
`timescale 1ns/1ns
module tb_pdh_top;
	import pdh_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic pd_en = 1'b0, use_a = 1'b0, use_b = 1'b0, sb_en = 1'b0, kp_en = 1'b0;
	logic [7:0] slew = 8'h00, dat = 8'h00, oe = 8'h00;
	logic [15:0] lp = 16'h0000, cl = 16'h0000, pt = 16'h0000;
	logic [5:0] bpad = 6'h00, bdrv = 6'h00;
	logic [1:0] req = 2'h0, spad;
	logic [7:0] pad_o, oe_o, slew_o, lvl_o;
	logic [15:0] cs_o, lp_o, fb_o;
	logic sl_o, sb_o;
	int n_mismatch = 0;
	int n_checks = 0;

	// ----------------------------------------------------------------
	// clock, partner and device
	// ----------------------------------------------------------------
	always #25 ref_clk_in = ~ref_clk_in;

	pdh_sleep_drv partner_u (.ref_clk_in(ref_clk_in), .req_in(req), .pad_out(spad));

	pdh_top dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_pd_enable_in(pd_en),
		.cfg_pd_use_a_in(use_a), .cfg_pd_use_b_in(use_b), .cfg_standby_en_in(sb_en),
		.cfg_keeper_en_in(kp_en), .cfg_fast_slew_in(slew), .cfg_cell_lowpwr_in(lp),
		.cell_logic_in(cl), .product_term_in(pt), .pin_data_in(dat), .pin_oe_in(oe),
		.pad_in({bpad, spad}), .pad_ext_drive_in({bdrv, 2'h3}), .pad_out(pad_o),
		.pad_oe_out(oe_o), .pad_fast_slew_out(slew_o), .pin_level_out(lvl_o),
		.cell_state_out(cs_o), .cell_lowpwr_out(lp_o), .foldback_bus_out(fb_o),
		.sleep_active_out(sl_o), .standby_out(sb_o));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	// one rising edge passes; outputs are settled at the falling edge
	task automatic step;
		@(negedge ref_clk_in);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk(16'(slew_o), 16'h0000, "slew not slow after reset");
		chk(fb_o, 16'hFFFF, "foldback reset");
		chk(16'(sl_o), 16'h0000, "asleep in reset");
	endtask

	task automatic t_cfg;
		pt = 16'hA5C3;
		slew = 8'h5A;
		lp = 16'h00F0;
		cl = 16'hFFFF;
		step;
		chk(fb_o, 16'h5A3C, "foldback not inverted");
		chk(16'(slew_o), 16'h005A, "slew per pin");
		chk(lp_o, 16'h00F0, "low power copy");
		chk(cs_o, 16'hFF0F, "low power cells");
		slew = 8'h00;
		lp = 16'h0000;
		step;
		chk(16'(slew_o), 16'h0000, "slew back to slow");
	endtask

	task automatic t_sleep(input logic b);
		logic [7:0] e_oe;
		logic [7:0] e_pad;
		e_oe = b ? 8'hFD : 8'hFE;
		e_pad = b ? 8'hC1 : 8'hC2;
		pd_en = 1'b1;
		use_a = ~b;
		use_b = b;
		oe = 8'hFF;
		dat = 8'hC3;
		cl = 16'h1234;
		bdrv = 6'h3F;
		bpad = 6'h15;
		step;
		chk(16'(oe_o), 16'(e_oe), "sleep pin drives");
		chk(16'(pad_o), 16'(e_pad), "sleep pin data driven");
		req[b] = 1'b1;
		step;
		cl = 16'hBEEF;
		oe = 8'h0F;
		dat = 8'h3C;
		bpad = 6'h2A;
		step;
		chk(16'(sl_o), 16'h0001, "no sleep");
		chk(cs_o, 16'h1234, "cells not held");
		chk(16'(oe_o), 16'(e_oe), "outputs not held");
		chk(16'(pad_o), 16'(e_pad), "output data not held");
		repeat (3) step;
		chk(16'(lvl_o[7:2]), 16'h0015, "pin change seen asleep");
		chk(cs_o, 16'h1234, "cells drift asleep");
		req[b] = 1'b0;
		step;
		step;
		chk(16'(sl_o), 16'h0000, "no wake");
		step;
		chk(cs_o, 16'hBEEF, "cells not resumed");
		chk(16'(lvl_o[7:2]), 16'h002A, "pins not resumed");
		chk(16'(pad_o), 16'h003C, "output data not resumed");
		chk(16'(oe_o), 16'(e_oe & 8'h0F), "output enables not resumed");
		pd_en = 1'b0;
		req[b] = 1'b1;
		repeat (3) step;
		chk(16'(sl_o), 16'h0000, "sleep with option off");
		req[b] = 1'b0;
		step;
	endtask

	task automatic t_standby;
		sb_en = 1'b1;
		// switched-down cells fed ones must not count as activity
		lp = 16'h000F;
		cl = 16'hFFFF;
		step;
		chk(16'(sb_o), 16'h0000, "standby despite activity");
		repeat (3) step;
		chk(16'(sb_o), 16'h0000, "standby too early");
		step;
		chk(16'(sb_o), 16'h0001, "no standby after quiet cycles");
		chk(cs_o, 16'hFFF0, "low power cells in standby");
		cl = 16'h0000;
		step;
		chk(16'(sb_o), 16'h0000, "standby through activity");
		sb_en = 1'b0;
		lp = 16'h0000;
	endtask

	task automatic t_keeper;
		kp_en = 1'b1;
		bdrv = 6'h3F;
		bpad = 6'h2D;
		step;
		chk(16'(lvl_o[7:2]), 16'h002D, "driven level");
		// a released pad shows the inverse so a stale value cannot pass
		bdrv = 6'h00;
		bpad = 6'h12;
		step;
		step;
		chk(16'(lvl_o[7:2]), 16'h002D, "keeper lost level");
		kp_en = 1'b0;
		step;
		step;
		chk(16'(lvl_o[7:2]), 16'({6{FLOAT_LEVEL}}), "float with keeper off");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) step;
		t_reset();
		step;
		rst_in = 1'b0;
		t_cfg();
		t_sleep(1'b0);
		t_sleep(1'b1);
		t_standby();
		t_keeper();
		end_of_test();
	end
endmodule

//--- rtl/pdh_keeper.sv
/*
 pdh_keeper: per-pin input sampling with optional keeper of the last driven level.
 assumes: ext_drive tells whether someone drives the pad; synchronous inputs.
*/
`timescale 1ns/1ns
module pdh_keeper #(
	parameter int N_PINS = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	pdh_pin_if.keeper pins
);
	import pdh_pkg::*;

	logic [N_PINS-1:0] level_reg;

	// ----------------------------------------------------------------
	// level capture
	// ----------------------------------------------------------------
	// frozen while asleep
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			level_reg <= {N_PINS{RST_LEVEL}};
		end else if (!pins.freeze) begin
			for (int i = 0; i < N_PINS; i++) begin
				if (pins.ext_drive[i]) begin
					level_reg[i] <= pins.pad[i];
				end else if (!pins.keeper_en) begin
					level_reg[i] <= FLOAT_LEVEL;
				end
			end
		end
	end

	assign pins.level = level_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_keeper_holds;
		@(posedge ref_clk_in) disable iff (rst_in)
		(!pins.freeze && pins.keeper_en) |=>
			(((pins.level ^ $past(pins.level)) & ~$past(pins.ext_drive)) == '0);
	endproperty
	a_keeper_holds: assert property (p_keeper_holds)
		else $error("keeper lost the level of an undriven pin");

	property p_frozen_level;
		@(posedge ref_clk_in) disable iff (rst_in)
		pins.freeze |=> $stable(pins.level);
	endproperty
	a_frozen_level: assert property (p_frozen_level)
		else $error("pin level moved during power-down");
endmodule

//--- rtl/pdh_pin_if.sv
/*
 pdh_pin_if: carries pad samples into the pin keeper and its held level back.
 assumes: one clock domain; the keeper module owns level.
*/
`timescale 1ns/1ns
interface pdh_pin_if #(
	parameter int N_PINS = 8
);
	logic [N_PINS-1:0] pad;
	logic [N_PINS-1:0] ext_drive;
	logic [N_PINS-1:0] level;
	logic freeze;
	logic keeper_en;

	modport keeper (
		input pad,
		input ext_drive,
		input freeze,
		input keeper_en,
		output level
	);
	modport ctrl (
		output pad,
		output ext_drive,
		output freeze,
		output keeper_en,
		input level
	);
endinterface

//--- rtl/pdh_pkg.sv
/*
 pdh_pkg: constants shared by the pin power-down and hold block.
 assumes: nothing beyond a SystemVerilog compiler.
*/
package pdh_pkg;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic RST_SLEEP = 1'b0;
	localparam logic RST_STANDBY = 1'b0;
	// slow edge rate is the default for every output
	localparam logic RST_SLEW_FAST = 1'b0;
	localparam logic RST_PAD_OE = 1'b0;
	localparam logic RST_PAD_DATA = 1'b0;
	localparam logic RST_CELL = 1'b0;
	localparam logic RST_LEVEL = 1'b0;
	// level read from an undriven pin while the keeper is off
	localparam logic FLOAT_LEVEL = 1'b0;

	// ----------------------------------------------------------------
	// structure and timing
	// ----------------------------------------------------------------
	// cells feeding one regional foldback bus
	localparam int REGION_CELLS = 16;
	// cells that each foldback term is offered to
	localparam int FOLDBACK_FANOUT = 4;
	// quiet cycles before standby is entered
	localparam int STANDBY_IDLE_CYC = 4;
endpackage

//--- rtl/pdh_top.sv
/*
 pdh_top: power-down hold, standby, per-cell reduced power, slew, keeper
 and foldback logic of a programmable logic device.
 assumes: all inputs synchronous to ref_clk_in; configuration inputs are
 static settings from the device configuration; fabric logic outside.
*/
`timescale 1ns/1ns
// What this block does
// - with power-down configured, either enabled sleep pin high puts the device asleep
// - asleep, all internal cell values and enabled outputs are held
// - asleep, pin transitions reach only the standby activity check until the sleep pin returns low
// - a designated sleep pin is never a logic input or output
// - with standby selected, no logic transitions drops the device into standby
// - each cell has its own reduced-power setting that switches it down
// - each output has its own edge rate, slow unless fast is configured
// - with keeper on, an undriven pin keeps its last driven level
// - each cell drives an inverted product term onto a shared regional bus
module pdh_top #(
	parameter int N_PINS = 8,
	parameter int N_CELLS = 16,
	parameter int SLEEP_A_IDX = 0,
	parameter int SLEEP_B_IDX = 1
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic cfg_pd_enable_in,
	input wire logic cfg_pd_use_a_in,
	input wire logic cfg_pd_use_b_in,
	input wire logic cfg_standby_en_in,
	input wire logic cfg_keeper_en_in,
	input wire logic [N_PINS-1:0] cfg_fast_slew_in,
	input wire logic [N_CELLS-1:0] cfg_cell_lowpwr_in,
	input wire logic [N_CELLS-1:0] cell_logic_in,
	input wire logic [N_CELLS-1:0] product_term_in,
	input wire logic [N_PINS-1:0] pin_data_in,
	input wire logic [N_PINS-1:0] pin_oe_in,
	input wire logic [N_PINS-1:0] pad_in,
	input wire logic [N_PINS-1:0] pad_ext_drive_in,
	output logic [N_PINS-1:0] pad_out,
	output logic [N_PINS-1:0] pad_oe_out,
	output logic [N_PINS-1:0] pad_fast_slew_out,
	output logic [N_PINS-1:0] pin_level_out,
	output logic [N_CELLS-1:0] cell_state_out,
	output logic [N_CELLS-1:0] cell_lowpwr_out,
	output logic [N_CELLS-1:0] foldback_bus_out,
	output logic sleep_active_out,
	output logic standby_out
);
	import pdh_pkg::*;

	localparam int CW = $clog2(STANDBY_IDLE_CYC + 1);

	if (N_PINS < 2 || SLEEP_A_IDX == SLEEP_B_IDX ||
		SLEEP_A_IDX < 0 || SLEEP_A_IDX >= N_PINS ||
		SLEEP_B_IDX < 0 || SLEEP_B_IDX >= N_PINS) begin
		$error("pdh_top: sleep pin indices must be distinct pins");
	end
	if (N_CELLS < REGION_CELLS || (N_CELLS % REGION_CELLS) != 0) begin
		$error("pdh_top: cell count must be whole regions");
	end

	function automatic logic [N_PINS-1:0] pin_bit(input int idx, input logic on);
		logic [N_PINS-1:0] m;
		m = '0;
		m[idx] = on;
		return m;
	endfunction

	// ----------------------------------------------------------------
	// sleep pin decode
	// ----------------------------------------------------------------
	logic sleep_pin_a;
	logic sleep_pin_b;
	logic sleep_now;
	logic [N_PINS-1:0] sleep_pin_mask;

	assign sleep_pin_a = cfg_pd_enable_in & cfg_pd_use_a_in & pad_in[SLEEP_A_IDX];
	assign sleep_pin_b = cfg_pd_enable_in & cfg_pd_use_b_in & pad_in[SLEEP_B_IDX];
	assign sleep_now = sleep_pin_a | sleep_pin_b;

	assign sleep_pin_mask = pin_bit(SLEEP_A_IDX, cfg_pd_enable_in & cfg_pd_use_a_in) |
		pin_bit(SLEEP_B_IDX, cfg_pd_enable_in & cfg_pd_use_b_in);

	// ----------------------------------------------------------------
	// pin keeper
	// ----------------------------------------------------------------
	pdh_pin_if #(.N_PINS(N_PINS)) pins ();

	// a sleep pin is forced to look driven low so logic never sees it
	assign pins.pad = pad_in & ~sleep_pin_mask;
	assign pins.ext_drive = pad_ext_drive_in | sleep_pin_mask;
	assign pins.freeze = sleep_now;
	assign pins.keeper_en = cfg_keeper_en_in;

	pdh_keeper #(.N_PINS(N_PINS)) u_keeper (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.pins(pins)
	);

	assign pin_level_out = pins.level;

	// ----------------------------------------------------------------
	// cells and foldback
	// ----------------------------------------------------------------
	logic [N_CELLS-1:0] cell_state_reg;
	logic [N_CELLS-1:0] cell_lowpwr_reg;
	logic [N_CELLS-1:0] foldback_reg;

	// hold cell values; resume from them
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cell_state_reg <= {N_CELLS{RST_CELL}};
		end else if (!sleep_now) begin
			cell_state_reg <= cell_logic_in & ~cfg_cell_lowpwr_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cell_lowpwr_reg <= '0;
		end else begin
			cell_lowpwr_reg <= cfg_cell_lowpwr_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			foldback_reg <= {N_CELLS{~RST_CELL}};
		end else if (!sleep_now) begin
			foldback_reg <= ~product_term_in;
		end
	end

	assign cell_state_out = cell_state_reg;
	assign cell_lowpwr_out = cell_lowpwr_reg;
	assign foldback_bus_out = foldback_reg;

	// ----------------------------------------------------------------
	// output pads
	// ----------------------------------------------------------------
	logic [N_PINS-1:0] pad_out_reg;
	logic [N_PINS-1:0] pad_oe_reg;
	logic [N_PINS-1:0] slew_reg;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pad_out_reg <= {N_PINS{RST_PAD_DATA}};
			pad_oe_reg <= {N_PINS{RST_PAD_OE}};
		end else if (!sleep_now) begin
			pad_out_reg <= pin_data_in & ~sleep_pin_mask;
			pad_oe_reg <= pin_oe_in & ~sleep_pin_mask;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			slew_reg <= {N_PINS{RST_SLEW_FAST}};
		end else begin
			slew_reg <= cfg_fast_slew_in;
		end
	end

	assign pad_out = pad_out_reg;
	assign pad_oe_out = pad_oe_reg;
	assign pad_fast_slew_out = slew_reg;

	// ----------------------------------------------------------------
	// sleep and standby status
	// ----------------------------------------------------------------
	logic sleep_reg;
	logic standby_reg;
	logic [CW-1:0] idle_cnt_reg;
	logic [N_PINS-1:0] pad_prev_reg;
	logic activity;

	// any change on awake cells or pads counts as a logic transition;
	// a switched-down cell never toggles, so its fabric input must not block standby
	assign activity = ((cell_logic_in & ~cfg_cell_lowpwr_in) != cell_state_reg) |
		(pad_in != pad_prev_reg);

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sleep_reg <= RST_SLEEP;
			pad_prev_reg <= '0;
		end else begin
			sleep_reg <= sleep_now;
			pad_prev_reg <= pad_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			idle_cnt_reg <= '0;
			standby_reg <= RST_STANDBY;
		end else if (!cfg_standby_en_in || activity) begin
			idle_cnt_reg <= '0;
			standby_reg <= 1'b0;
		end else begin
			if (idle_cnt_reg != CW'(STANDBY_IDLE_CYC)) begin
				idle_cnt_reg <= idle_cnt_reg + CW'(1);
			end
			standby_reg <= (idle_cnt_reg >= CW'(STANDBY_IDLE_CYC - 1));
		end
	end

	assign sleep_active_out = sleep_reg;
	assign standby_out = standby_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_release;
		sleep_now ##1 !sleep_now;
	endsequence

	property p_sleep_enter;
		(cfg_pd_enable_in && ((cfg_pd_use_a_in && pad_in[SLEEP_A_IDX]) ||
			(cfg_pd_use_b_in && pad_in[SLEEP_B_IDX]))) |=> sleep_active_out;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter)
		else $error("enabled sleep pin high did not enter power-down");

	property p_sleep_off;
		!cfg_pd_enable_in |=> !sleep_active_out;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("power-down entered while not configured");

	property p_hold_cells;
		sleep_now |=> ($stable(cell_state_out) && $stable(foldback_bus_out));
	endproperty
	a_hold_cells: assert property (p_hold_cells)
		else $error("cell values changed during power-down");

	property p_hold_pads;
		sleep_now |=> ($stable(pad_out) && $stable(pad_oe_out));
	endproperty
	a_hold_pads: assert property (p_hold_pads)
		else $error("outputs changed during power-down");

	property p_sleep_pin_free;
		(cfg_pd_enable_in && cfg_pd_use_a_in && !sleep_now) |=>
			(!pad_oe_out[SLEEP_A_IDX] && !pin_level_out[SLEEP_A_IDX]);
	endproperty
	a_sleep_pin_free: assert property (p_sleep_pin_free)
		else $error("designated sleep pin used as logic pin");

	property p_standby;
		standby_out |-> ($past(cfg_standby_en_in) && !$past(activity) &&
			$past(idle_cnt_reg) >= CW'(STANDBY_IDLE_CYC - 1));
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby without enough quiet cycles");

	property p_lowpwr;
		!sleep_now |=> ((cell_state_out & $past(cfg_cell_lowpwr_in)) == '0);
	endproperty
	a_lowpwr: assert property (p_lowpwr)
		else $error("reduced-power cell still active");

	property p_slew;
		1'b1 |=> (pad_fast_slew_out == $past(cfg_fast_slew_in));
	endproperty
	a_slew: assert property (p_slew)
		else $error("slew setting not applied");

	property p_foldback;
		!sleep_now |=> (foldback_bus_out == ~$past(product_term_in));
	endproperty
	a_foldback: assert property (p_foldback)
		else $error("foldback term not the inverted product term");

	property p_resume;
		s_release |-> (cell_state_out == $past(cell_state_out)) ##1
			(cell_state_out == ($past(cell_logic_in) & ~$past(cfg_cell_lowpwr_in)));
	endproperty
	a_resume: assert property (p_resume)
		else $error("no resume from held values after power-down");
endmodule
